// ===== rtl/cba_pkg.sv
// Types and constants of the circular and bit-reversed address generator
// Behaviour
// (RULE_01) X circular needs select not 15, bit 15
// (RULE_02) Y circular needs select not 15, bit 14
// (RULE_03) Select 15 disables that space's correction
// (RULE_04) Bound test catches overshoot, not only equality
// (RULE_05) Write back only pre/post modify modes
// (RULE_06) Reverse needs select, enable, pre/post increment
// (RULE_07) Reverse only on X word writes
// (RULE_08) Only the modifier is bit reversed
// (RULE_09) Increments visit indices in reversed order
// (RULE_10) Software aligns reversed buffer to its size
// (RULE_11) Pivot scaled to byte addresses
// (RULE_12) Byte or other modes give normal addresses
// (RULE_13) Reverse adds pivot, drops offset, clears bit0
// (RULE_14) Reverse beats circular on X write only
// (RULE_15) Software avoids read right after pivot write
// (RULE_16) Software sets pivot to half buffer words
// (RULE_17) Start and end registers bound each buffer
// (RULE_18) Y circular addresses keep bit 0 clear; in post modify modes only wb_ptr is cleared, the address is the old pointer
// (RULE_19) Wrap by subtracting or adding buffer length
package cba_pkg;

    localparam int CBA_DW = 16;
    localparam int CBA_RAW = 3;

    // ************************************************
    // Register map, word indices
    // ************************************************
    localparam logic [CBA_RAW-1:0] CBA_REG_CTL = 3'h0;
    localparam logic [CBA_RAW-1:0] CBA_REG_REV = 3'h1;
    localparam logic [CBA_RAW-1:0] CBA_REG_XSTART = 3'h2;
    localparam logic [CBA_RAW-1:0] CBA_REG_XEND = 3'h3;
    localparam logic [CBA_RAW-1:0] CBA_REG_YSTART = 3'h4;
    localparam logic [CBA_RAW-1:0] CBA_REG_YEND = 3'h5;

    localparam logic [15:0] CBA_CTL_RST = 16'h0000;
    localparam logic [15:0] CBA_REV_RST = 16'h0000;
    localparam logic [15:0] CBA_BUF_RST = 16'h0000;
    localparam logic [15:0] CBA_CTL_WMASK = 16'hCFFF;
    localparam logic [3:0] CBA_SEL_OFF = 4'hF;

    // ************************************************
    // Register layouts
    // ************************************************
    typedef struct packed {
        logic x_circular_enable;
        logic y_circular_enable;
        logic [1:0] rsvd;
        logic [3:0] reverse_pointer_select;
        logic [3:0] y_pointer_select;
        logic [3:0] x_pointer_select;
    } cba_ctl_t;

    typedef struct packed {
        logic reverse_enable;
        logic [14:0] reverse_pivot;
    } cba_rev_t;

    typedef enum logic [1:0] {CBA_SP_XRD, CBA_SP_XWR, CBA_SP_Y} cba_space_t;

    typedef enum logic [2:0] {
        CBA_MD_IND, CBA_MD_POST_INC, CBA_MD_POST_DEC,
        CBA_MD_PRE_INC, CBA_MD_PRE_DEC, CBA_MD_REG_OFS
    } cba_mode_t;

    // ************************************************
    // Request and answer carriers
    // ************************************************
    typedef struct packed {
        logic valid;
        cba_space_t space;
        logic [3:0] ptr_idx;
        logic [15:0] ptr;
        cba_mode_t mode;
        logic [15:0] offset;
        logic byte_acc;
    } cba_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] effective_address;
        logic wb_en;
        logic [3:0] wb_idx;
        logic [15:0] wb_ptr;
        logic circ_used;
        logic rev_used;
    } cba_res_t;

endpackage

// ===== rtl/cba_addr_gen.sv
// Circular and bit-reversed effective address generator with its registers
module cba_addr_gen
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [cba_pkg::CBA_RAW-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire cba_pkg::cba_req_t req_i,
    output cba_pkg::cba_res_t res_o
);
    import cba_pkg::*;

    typedef struct packed {
        cba_ctl_t ctl;
        cba_rev_t rev;
        logic [15:0] x_buffer_start;
        logic [15:0] x_buffer_end;
        logic [15:0] y_buffer_start;
        logic [15:0] y_buffer_end;
        logic [15:0] rdata;
        cba_res_t res;
    } cba_state_t;

    cba_state_t s_q;
    cba_state_t s_d;

    // ************************************************
    // Address helpers
    // ************************************************
    function automatic logic [15:0] cba_rev16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++)
        begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

    // Carry runs toward bit 0; only the modifier acts reversed
    function automatic logic [15:0] cba_rev_add(input logic [15:0] p, input logic [14:0] pv);
        logic [15:0] m;
        logic [15:0] sum;
        m = {pv, 1'b0}; // see (RULE_11)
        sum = cba_rev16(16'(cba_rev16(p) + cba_rev16(m))); // see (RULE_08) see (RULE_09)
        return {sum[15:1], 1'b0}; // see (RULE_13)
    endfunction

    function automatic logic [15:0] cba_wrap(input logic [15:0] a, input logic [15:0] lo,
        input logic [15:0] hi, input logic inc);
        logic [15:0] len;
        logic [15:0] r;
        len = 16'(hi - lo + 16'h0001); // see (RULE_17)
        r = a;
        if (inc && (a > hi)) // see (RULE_04)
        begin
            r = 16'(a - len); // see (RULE_19)
        end
        else if (!inc && (a < lo)) // see (RULE_04)
        begin
            r = 16'(a + len); // see (RULE_19)
        end
        return r;
    endfunction

    // ************************************************
    // Request decode
    // ************************************************
    logic is_x;
    logic is_inc;
    logic is_pre;
    logic is_post;
    logic circ_on;
    logic rev_on;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] stepped;
    logic [15:0] fixed;

    always_comb
    begin
        is_x = (req_i.space != CBA_SP_Y);
        is_inc = (req_i.mode == CBA_MD_POST_INC) || (req_i.mode == CBA_MD_PRE_INC)
            || (req_i.mode == CBA_MD_REG_OFS);
        is_pre = (req_i.mode == CBA_MD_PRE_INC) || (req_i.mode == CBA_MD_PRE_DEC);
        is_post = (req_i.mode == CBA_MD_POST_INC) || (req_i.mode == CBA_MD_POST_DEC);
        // Reverse path: X writes of words in pre/post increment modes only
        rev_on = (req_i.space == CBA_SP_XWR) && !req_i.byte_acc // see (RULE_07) see (RULE_12)
            && (req_i.mode == CBA_MD_PRE_INC || req_i.mode == CBA_MD_POST_INC) // see (RULE_06)
            && s_q.rev.reverse_enable // see (RULE_06)
            && (s_q.ctl.reverse_pointer_select != CBA_SEL_OFF) // see (RULE_06)
            && (req_i.ptr_idx == s_q.ctl.reverse_pointer_select);
        if (is_x)
        begin
            circ_on = s_q.ctl.x_circular_enable // see (RULE_01)
                && (s_q.ctl.x_pointer_select != CBA_SEL_OFF) // see (RULE_01) see (RULE_03)
                && (req_i.ptr_idx == s_q.ctl.x_pointer_select)
                && !rev_on; // see (RULE_14)
            lo = s_q.x_buffer_start;
            hi = s_q.x_buffer_end;
        end
        else
        begin
            circ_on = s_q.ctl.y_circular_enable // see (RULE_02)
                && (s_q.ctl.y_pointer_select != CBA_SEL_OFF) // see (RULE_02) see (RULE_03)
                && (req_i.ptr_idx == s_q.ctl.y_pointer_select);
            lo = s_q.y_buffer_start;
            hi = s_q.y_buffer_end;
        end
        circ_on = circ_on && (req_i.mode != CBA_MD_IND);
        if (is_inc)
        begin
            stepped = 16'(req_i.ptr + req_i.offset);
        end
        else
        begin
            stepped = 16'(req_i.ptr - req_i.offset);
        end
        fixed = circ_on ? cba_wrap(stepped, lo, hi, is_inc) : stepped;
        if (circ_on && !is_x)
        begin
            fixed[0] = 1'b0; // see (RULE_18)
        end
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.rdata = '0;
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                CBA_REG_CTL: s_d.ctl = cba_ctl_t'(reg_wdata_i & CBA_CTL_WMASK);
                CBA_REG_REV: s_d.rev = cba_rev_t'(reg_wdata_i);
                CBA_REG_XSTART: s_d.x_buffer_start = reg_wdata_i;
                CBA_REG_XEND: s_d.x_buffer_end = reg_wdata_i;
                CBA_REG_YSTART: s_d.y_buffer_start = reg_wdata_i;
                CBA_REG_YEND: s_d.y_buffer_end = reg_wdata_i;
                default: s_d.ctl = s_q.ctl;
            endcase
        end
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                CBA_REG_CTL: s_d.rdata = s_q.ctl;
                CBA_REG_REV: s_d.rdata = s_q.rev;
                CBA_REG_XSTART: s_d.rdata = s_q.x_buffer_start;
                CBA_REG_XEND: s_d.rdata = s_q.x_buffer_end;
                CBA_REG_YSTART: s_d.rdata = s_q.y_buffer_start;
                CBA_REG_YEND: s_d.rdata = s_q.y_buffer_end;
                default: s_d.rdata = '0;
            endcase
        end
        s_d.res = '0;
        s_d.res.valid = req_i.valid;
        s_d.res.wb_idx = req_i.ptr_idx;
        if (req_i.valid)
        begin
            s_d.res.circ_used = circ_on;
            s_d.res.rev_used = rev_on;
            s_d.res.wb_en = is_pre || is_post; // see (RULE_05)
            if (rev_on)
            begin
                s_d.res.wb_ptr = cba_rev_add(req_i.ptr, s_q.rev.reverse_pivot); // see (RULE_13)
                s_d.res.effective_address = is_pre ? s_d.res.wb_ptr
                    : {req_i.ptr[15:1], 1'b0}; // see (RULE_13)
            end
            else
            begin
                case (req_i.mode)
                    CBA_MD_IND:
                    begin
                        s_d.res.effective_address = req_i.ptr;
                    end
                    CBA_MD_POST_INC, CBA_MD_POST_DEC:
                    begin
                        s_d.res.effective_address = req_i.ptr;
                        s_d.res.wb_ptr = fixed;
                    end
                    CBA_MD_PRE_INC, CBA_MD_PRE_DEC:
                    begin
                        s_d.res.effective_address = fixed;
                        s_d.res.wb_ptr = fixed;
                    end
                    CBA_MD_REG_OFS:
                    begin
                        s_d.res.effective_address = fixed; // see (RULE_05)
                    end
                    default:
                    begin
                        s_d.res.effective_address = req_i.ptr;
                    end
                endcase
            end
        end
    end

    // ************************************************
    // State register
    // ************************************************
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            s_q <= '0;
            s_q.ctl <= cba_ctl_t'(CBA_CTL_RST);
            s_q.rev <= cba_rev_t'(CBA_REV_RST);
            s_q.x_buffer_start <= CBA_BUF_RST;
            s_q.x_buffer_end <= CBA_BUF_RST;
            s_q.y_buffer_start <= CBA_BUF_RST;
            s_q.y_buffer_end <= CBA_BUF_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o = s_q.rdata;
    assign res_o = s_q.res;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    x_circ_gate_a: assert property ( // see (RULE_01)
        res_o.circ_used && $past(req_i.space) != CBA_SP_Y
        |-> $past(s_q.ctl.x_circular_enable) && $past(s_q.ctl.x_pointer_select) != 4'hF)
        else $error("X circular used while disabled");

    y_circ_gate_a: assert property ( // see (RULE_02)
        res_o.circ_used && $past(req_i.space) == CBA_SP_Y
        |-> $past(s_q.ctl.y_circular_enable) && $past(s_q.ctl.y_pointer_select) != 4'hF)
        else $error("Y circular used while disabled");

    sel_off_a: assert property ( // see (RULE_03)
        req_i.valid && req_i.space == CBA_SP_Y && s_q.ctl.y_pointer_select == 4'hF
        |=> !res_o.circ_used)
        else $error("Select of 15 did not disable Y circular");

    overshoot_wrap_a: assert property ( // see (RULE_04)
        req_i.valid && req_i.mode == CBA_MD_PRE_INC && req_i.space == CBA_SP_Y
        && circ_on && stepped > s_q.y_buffer_end && stepped <= 16'hFF00
        |=> res_o.effective_address
        == (16'($past(stepped) - ($past(s_q.y_buffer_end) - $past(s_q.y_buffer_start) + 16'h1))
        & 16'hFFFE))
        else $error("Overshoot past end not wrapped by length");

    x_wrap_inc_a: assert property ( // see (RULE_19)
        req_i.valid && req_i.mode == CBA_MD_PRE_INC && req_i.space == CBA_SP_XRD
        && circ_on && stepped > s_q.x_buffer_end && stepped <= 16'hFF00
        |=> res_o.effective_address == 16'($past(req_i.ptr) + $past(req_i.offset)
        - ($past(s_q.x_buffer_end) - $past(s_q.x_buffer_start) + 16'h1)))
        else $error("X overshoot past end not wrapped by length");

    y_wrap_dec_a: assert property ( // see (RULE_19)
        req_i.valid && req_i.mode == CBA_MD_PRE_DEC && req_i.space == CBA_SP_Y
        && circ_on && stepped < s_q.y_buffer_start && stepped >= 16'h0100
        |=> res_o.effective_address == (16'($past(req_i.ptr) - $past(req_i.offset)
        + ($past(s_q.y_buffer_end) - $past(s_q.y_buffer_start) + 16'h1)) & 16'hFFFE))
        else $error("Y undershoot below start not wrapped by length");

    ind_plain_a: assert property ( // see (RULE_05)
        req_i.valid && req_i.mode == CBA_MD_IND
        |=> res_o.effective_address == $past(req_i.ptr) && !res_o.wb_en && !res_o.circ_used)
        else $error("Plain indirect access modified address or pointer");

    ofs_no_wb_a: assert property ( // see (RULE_05)
        req_i.valid && req_i.mode == CBA_MD_REG_OFS ##1 res_o.valid |-> !res_o.wb_en)
        else $error("Register offset mode wrote back");

    prepost_wb_a: assert property ( // see (RULE_05)
        req_i.valid && (req_i.mode == CBA_MD_PRE_DEC || req_i.mode == CBA_MD_POST_DEC)
        |=> res_o.wb_en && res_o.wb_idx == $past(req_i.ptr_idx))
        else $error("Modify mode missed write back");

    rev_scope_a: assert property ( // see (RULE_07) see (RULE_12)
        res_o.rev_used |-> $past(req_i.space) == CBA_SP_XWR && !$past(req_i.byte_acc)
        && ($past(req_i.mode) == CBA_MD_PRE_INC || $past(req_i.mode) == CBA_MD_POST_INC))
        else $error("Reversal outside X word increment writes");

    rev_gate_a: assert property ( // see (RULE_06)
        res_o.rev_used |-> $past(s_q.rev.reverse_enable)
        && $past(s_q.ctl.reverse_pointer_select) != 4'hF)
        else $error("Reversal while disabled");

    rev_seq_a: assert property ( // see (RULE_09) see (RULE_11)
        req_i.valid && rev_on && req_i.mode == CBA_MD_POST_INC
        && s_q.rev.reverse_pivot == 15'h0008 && req_i.ptr[4:0] == 5'h10
        |=> res_o.wb_ptr[4:0] == 5'h08 && res_o.wb_ptr[15:5] == $past(req_i.ptr[15:5]))
        else $error("Reversed step from index 8 did not reach index 4");

    rev_lsb_a: assert property ( // see (RULE_13)
        res_o.rev_used |-> !res_o.effective_address[0] && !res_o.wb_ptr[0] && !res_o.circ_used)
        else $error("Reversed address has bit 0 set or circular");

    rev_pre_ea_a: assert property ( // see (RULE_13)
        res_o.rev_used && $past(req_i.mode) == CBA_MD_PRE_INC
        |-> res_o.effective_address == res_o.wb_ptr)
        else $error("Reversed pre-increment address differs from new pointer");

    rev_post_ea_a: assert property ( // see (RULE_13)
        res_o.rev_used && $past(req_i.mode) == CBA_MD_POST_INC
        |-> res_o.effective_address == {$past(req_i.ptr[15:1]), 1'b0})
        else $error("Reversed post-increment address is not the old pointer");

    byte_norm_a: assert property ( // see (RULE_12)
        req_i.valid && req_i.space == CBA_SP_XWR && req_i.byte_acc
        && req_i.mode == CBA_MD_PRE_INC && !circ_on
        |=> !res_o.rev_used
        && res_o.effective_address == 16'($past(req_i.ptr) + $past(req_i.offset)))
        else $error("Byte write got a reversed address");

    rev_prio_a: assert property ( // see (RULE_14)
        req_i.valid && req_i.space == CBA_SP_XRD && s_q.ctl.x_circular_enable
        && s_q.ctl.x_pointer_select != 4'hF && req_i.ptr_idx == s_q.ctl.x_pointer_select
        && req_i.mode == CBA_MD_POST_INC
        |=> res_o.circ_used && !res_o.rev_used)
        else $error("X read lost circular correction");

    xwr_circ_a: assert property ( // see (RULE_14)
        req_i.valid && req_i.space == CBA_SP_XWR && req_i.byte_acc && s_q.ctl.x_circular_enable
        && s_q.ctl.x_pointer_select != 4'hF && req_i.ptr_idx == s_q.ctl.x_pointer_select
        && req_i.mode != CBA_MD_IND
        |=> res_o.circ_used)
        else $error("X write lost circular correction without reversal");

    y_lsb_a: assert property ( // see (RULE_18)
        res_o.circ_used && $past(req_i.space) == CBA_SP_Y && $past(req_i.mode) != CBA_MD_POST_INC
        && $past(req_i.mode) != CBA_MD_POST_DEC |-> !res_o.effective_address[0])
        else $error("Y circular address has bit 0 set");

    rd_ctl_a: assert property (
        reg_rd_i && reg_addr_i == CBA_REG_CTL && !reg_wr_i |=> reg_rdata_o == $past(s_q.ctl))
        else $error("Control read back wrong");

    rdata_idle_a: assert property (
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("Read data shown without a read");

    cov_rev_c: cover property (res_o.valid && res_o.rev_used);
    cov_xwrap_c: cover property (res_o.circ_used && res_o.wb_en && $past(req_i.space) != CBA_SP_Y);
    cov_ofs_c: cover property (res_o.circ_used && !res_o.wb_en);
    cov_both_c: cover property (res_o.rev_used ##1 res_o.circ_used);
    cov_ydec_c: cover property (res_o.circ_used && $past(req_i.space) == CBA_SP_Y
        && $past(req_i.mode) == CBA_MD_PRE_DEC);

endmodule

// ===== testbench/cba_core_model.sv
// Pointer register file of the execution path
module cba_core_model
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire cba_pkg::cba_res_t res_i,
    input wire logic [3:0] idx_i,
    output logic [15:0] ptr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import cba_pkg::*;
    logic [15:0] w_q [16];
    assign ptr_o = w_q[idx_i];
    // ****
    // Caller stores returned pointer
    // ****
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            w_q <= '{default: 16'h0000};
        else if (res_i.valid && res_i.wb_en)
            w_q[res_i.wb_idx] <= res_i.wb_ptr;
    end
endmodule

// ===== testbench/circular_bitrev_address_gen_tb.sv
// Self-checking bench of the address generator
module circular_bitrev_address_gen_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cba_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] reg_addr_i = 3'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    cba_req_t req_i = '0;
    cba_res_t res_o;
    logic [15:0] mptr;
    logic rd_seen = 1'b0;
    int n_mismatch = 0;
    int comparisons = 0;
    integer seed = 32'hD6B2;
    logic [15:0] rq [$];
    cba_res_t aq [$];
    logic [15:0] m_ctl = 16'h0000;
    logic [15:0] m_rev = 16'h0000;
    logic [15:0] m_b [4] = '{default: 16'h0000};
    logic [15:0] ctl_tab [4] = '{16'hC232, 16'hC3F3, 16'h4F3F, 16'h8433};

    cba_addr_gen u_dut (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .req_i, .res_o);
    cba_core_model u_core (.core_clk_i, .rst_n_i, .res_i(res_o), .idx_i(req_i.ptr_idx),
        .ptr_o(mptr));

    initial
        forever #10 core_clk_i = ~core_clk_i;

    // ****
    // Reference model
    // ****
    function automatic logic [15:0] rv(input logic [15:0] v);
        for (int i = 0; i < 16; i++)
            rv[i] = v[15-i];
    endfunction

    function automatic cba_res_t ref_res(input cba_req_t r);
        logic [15:0] s, e, a;
        logic inc, circ, rev, y;
        cba_res_t x;
        x = '0;
        y = r.space == CBA_SP_Y;
        s = y ? m_b[2] : m_b[0];
        e = y ? m_b[3] : m_b[1];
        if (y)
            circ = m_ctl[14] && m_ctl[7:4] != 4'hF && r.ptr_idx == m_ctl[7:4];
        else
            circ = m_ctl[15] && m_ctl[3:0] != 4'hF && r.ptr_idx == m_ctl[3:0];
        rev = r.space == CBA_SP_XWR && m_ctl[11:8] != 4'hF && m_rev[15] && !r.byte_acc
            && r.ptr_idx == m_ctl[11:8] && r.mode inside {CBA_MD_POST_INC, CBA_MD_PRE_INC};
        inc = r.mode inside {CBA_MD_POST_INC, CBA_MD_PRE_INC, CBA_MD_REG_OFS};
        a = inc ? r.ptr + r.offset : r.ptr - r.offset;
        if (circ && !rev && r.mode != CBA_MD_IND)
        begin
            if (inc && a > e)
                a = a - (e - s + 16'h0001);
            if (!inc && a < s)
                a = a + (e - s + 16'h0001);
            if (y)
                a[0] = 1'b0;
        end
        if (rev)
            a = rv(rv(r.ptr) + rv({m_rev[14:0], 1'b0})) & 16'hFFFE;
        x.valid = 1'b1;
        x.wb_idx = r.ptr_idx;
        x.rev_used = rev;
        x.circ_used = circ && !rev && r.mode != CBA_MD_IND;
        x.wb_en = !(r.mode inside {CBA_MD_IND, CBA_MD_REG_OFS});
        x.wb_ptr = a;
        if (r.mode == CBA_MD_IND)
            x.effective_address = r.ptr;
        else if (r.mode inside {CBA_MD_POST_INC, CBA_MD_POST_DEC})
            x.effective_address = rev ? r.ptr & 16'hFFFE : r.ptr;
        else
            x.effective_address = a;
        return x;
    endfunction

    // ****
    // Drivers, compares, watcher
    // ****
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        req_i.valid <= 1'b0;
        if (a == 3'h0)
            m_ctl = d & CBA_CTL_WMASK;
        else if (a == 3'h1)
            m_rev = d;
        else if (a < 3'h6)
            m_b[a-3'h2] = d;
        @(posedge core_clk_i);
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] ex);
        rq.push_back(ex);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        reg_wr_i <= 1'b0;
        req_i.valid <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rqs(input cba_req_t r);
        aq.push_back(ref_res(r));
        req_i <= r;
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic idle();
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        req_i.valid <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic cmp_reg(input logic [15:0] g, input logic [15:0] ex);
        comparisons++;
        if (g !== ex)
        begin
            n_mismatch++;
            $display("[ERR] %0t data got %h exp %h", $time, g, ex);
        end
    endtask

    task automatic cmp_res(input cba_res_t g, input cba_res_t ex);
        comparisons++;
        if (g.valid !== ex.valid || g.effective_address !== ex.effective_address
            || g.wb_en !== ex.wb_en || g.wb_idx !== ex.wb_idx || g.rev_used !== ex.rev_used
            || g.circ_used !== ex.circ_used
            || (ex.wb_en && g.wb_ptr !== ex.wb_ptr))
        begin
            n_mismatch++;
            $display("[ERR] %0t result got %h exp %h", $time, g, ex);
        end
    endtask

    always @(posedge core_clk_i)
        rd_seen <= reg_rd_i;

    always @(negedge core_clk_i)
    begin
        if (rd_seen)
            cmp_reg(reg_rdata_o, rq.size() ? rq.pop_front() : 16'hDEAD);
        else
            cmp_reg(reg_rdata_o, 16'h0000);
        if (res_o.valid === 1'b1)
            cmp_res(res_o, aq.size() ? aq.pop_front() : '0);
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****
    // Main sequence
    // ****
    initial
    begin
        cba_req_t r;
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(i[2:0], 16'h0000);
        wr(3'h0, 16'hFFFF);
        rd(3'h0, 16'hCFFF);
        wr(3'h6, 16'h1234);
        rd(3'h6, 16'h0000);
        wr(3'h1, 16'hFFFF);
        rd(3'h1, 16'hFFFF);
        $display("test registers done");
        wr(3'h2, 16'h1000);
        wr(3'h3, 16'h103F);
        wr(3'h4, 16'h1800);
        wr(3'h5, 16'h183F);
        for (int k = 0; k < 4; k++)
        begin
            wr(3'h0, ctl_tab[k]);
            wr(3'h1, k == 0 ? 16'h0010 : 16'h8010);
            idle();
            repeat (80)
            begin
                r = '0;
                r.valid = 1'b1;
                r.space = cba_space_t'(2'($unsigned($random(seed)) % 3));
                r.ptr_idx = 4'h2 + 4'($unsigned($random(seed)) % 4);
                r.mode = cba_mode_t'(3'($unsigned($random(seed)) % 6));
                r.ptr = (r.space == CBA_SP_Y ? 16'h1800 : 16'h1000)
                    + (16'($random(seed)) & 16'h003E);
                r.offset = 16'($random(seed)) & 16'h000E;
                r.byte_acc = 1'($random(seed));
                rqs(r);
            end
            idle();
        end
        $display("test random requests done");
        wr(3'h0, 16'h02FF);
        wr(3'h1, 16'h8008);
        idle();
        r = '0;
        r.valid = 1'b1;
        r.space = CBA_SP_XWR;
        r.ptr_idx = 4'h2;
        r.mode = CBA_MD_POST_INC;
        r.offset = 16'h0002;
        for (int k = 0; k < 16; k++)
        begin
            r.ptr = k == 0 ? 16'h0800 : mptr;
            rqs(r);
            idle();
            idle();
            if (k == 0)
                cmp_reg(mptr, 16'h0810);
            if (k == 2)
                cmp_reg(mptr, 16'h0818);
        end
        cmp_reg(mptr, 16'h0800);
        $display("test reversed sequence done");
        for (int i = 0; i < 20 && (rq.size() || aq.size()); i++)
            @(posedge core_clk_i);
        if (rq.size() || aq.size())
            n_mismatch++;
        print_verdict();
    end
endmodule
